// *** shared/mcsf_defines.svh ***
// register offsets, field positions and reset values for the status flag bank
`ifndef MCSF_DEFINES_SVH
`define MCSF_DEFINES_SVH
// ***********************************
// register byte offsets
// ***********************************
`define MCSF_OFF_FLAGS 12'h000
`define MCSF_OFF_PEER 12'h004
`define MCSF_OFF_PGA_DET0 12'h008
`define MCSF_OFF_PGA_DET1 12'h00c
`define MCSF_OFF_PGA_DET2 12'h010
`define MCSF_OFF_TRQ_DET0 12'h014
`define MCSF_OFF_TRQ_DET1 12'h018
`define MCSF_OFF_SRV_DET0 12'h01c
`define MCSF_OFF_SRV_DET1 12'h020
`define MCSF_OFF_IRQ_STAT 12'h024
`define MCSF_OFF_IRQ_MASK 12'h028
`define MCSF_OFF_DOWN_CODE 12'h02c
// ***********************************
// field positions
// ***********************************
`define MCSF_BIT_PGA 0
`define MCSF_BIT_TRQ 1
`define MCSF_BIT_SRV 2
`define MCSF_BIT_DOWN 3
`define MCSF_PEER_DONE_LSB 0
`define MCSF_PEER_RST_LSB 4
`define MCSF_PEER_STOP_LSB 8
// irq status layout: 0 pga, 1 trq, 2 srv, 3 down, 7:4 read done per cpu
`define MCSF_IRQ_W 8
// ***********************************
// values
// ***********************************
`define MCSF_DOWN_ERR_CODE 16'h1b58
`define MCSF_RESET_WORD 32'h0000_0000
`define MCSF_IRQ_RESET 8'h00
`endif

// *** shared/mcsf_pkg.sv ***
// types shared by the status flag bank
package mcsf_pkg;
   // apb slave phase
   typedef enum logic [1:0] {
      MCSF_IDLE,
      MCSF_SETUP,
      MCSF_ACCESS
   } mcsf_apb_type;
   typedef logic [15:0] mcsf_word_type;
endpackage : mcsf_pkg

// *** verilog/mcsf_status_flags.sv ***
// status flag bank of a motion cpu with apb register access
`timescale 1ns/100ps
`include "mcsf_defines.svh"
// ***********************************
// Function
// - pulse axis error flag high while any of six setting words is abnormal
// - on pulse axis error rising, capture three detail words
// - test request error flag high when a test request fails
// - on test request error rising, capture two detail words
// - servo program data checked on invoke; abnormal data sets servo error flag
// - servo program error captures two detail words
// - read done flag of a cpu rises when a peer read finishes normally
// - reset flag of each cpu follows that cpu's reset state
// - a removed cpu counts as resetting
// - reset of cpu one makes all other cpus reset too
// - reset of cpu two to four raises multi cpu down error code while cpu one is not in reset
// - stop error flag only on stop error, not on continuation error
// ***********************************
module mcsf_status_flags #(
   parameter int NCPU = 4,
   parameter int NAXW = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pulse generator axis check results
   input wire logic [NAXW-1:0] pulse_gen_axis_setting_bad,
   input wire logic [47:0] pulse_gen_axis_error_info,
   // test mode request result
   input wire logic test_req_fail,
   input wire logic [31:0] test_req_error_info,
   // servo program check
   input wire logic servo_prog_check,
   input wire logic servo_prog_bad,
   input wire logic [31:0] servo_prog_error_info,
   // peer cpu status
   input wire logic [NCPU-1:0] peer_read_ok,
   input wire logic [NCPU-1:0] cpu_in_reset,
   input wire logic [NCPU-1:0] cpu_removed,
   input wire logic [NCPU-1:0] cpu_stop_error,
   input wire logic [NCPU-1:0] cpu_cont_error,
   // outputs
   output logic multi_cpu_down,
   output logic irq
);
   // ***********************************
   // flag state
   // ***********************************
   logic pga_flag_reg;
   logic trq_flag_reg;
   logic srv_flag_reg;
   logic [NCPU-1:0] done_reg;
   logic [NCPU-1:0] in_reset_reg;
   logic [NCPU-1:0] stop_reg;
   logic [15:0] pga_det_reg [3];
   logic [15:0] trq_det_reg [2];
   logic [15:0] srv_det_reg [2];
   logic [`MCSF_IRQ_W-1:0] irq_stat_reg;
   logic [`MCSF_IRQ_W-1:0] irq_mask_reg;
   logic [`MCSF_IRQ_W-1:0] irq_event;
   logic [NCPU-1:0] in_reset_next;
   logic down_next;
   mcsf_pkg::mcsf_apb_type phase_reg;
   logic wr_en;

   // a write commits only on the ready beat, so a held access cannot write twice
   assign wr_en = psel && penable && pwrite && pready;

   // word compare, used by the write decode and the assertions; the read mux uses a case on paddr
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   // ***********************************
   // error flags and details
   // ***********************************
   // pulse axis flag is a live level of the six word checks
   always_ff @(posedge clk) begin
      if (rst) begin
         pga_flag_reg <= 1'b0;
      end else begin
         pga_flag_reg <= |pulse_gen_axis_setting_bad;
      end
   end

   // details latched only on the rising edge so software sees the first cause
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            pga_det_reg[i] <= 16'h0000;
         end
      end else if (|pulse_gen_axis_setting_bad && !pga_flag_reg) begin
         for (int i = 0; i < 3; i++) begin
            pga_det_reg[i] <= pulse_gen_axis_error_info[16*i +: 16];
         end
      end
   end

   // test request flag follows the outcome of the latest request
   always_ff @(posedge clk) begin
      if (rst) begin
         trq_flag_reg <= 1'b0;
         trq_det_reg[0] <= 16'h0000;
         trq_det_reg[1] <= 16'h0000;
      end else begin
         trq_flag_reg <= test_req_fail;
         if (test_req_fail && !trq_flag_reg) begin
            trq_det_reg[0] <= test_req_error_info[15:0];
            trq_det_reg[1] <= test_req_error_info[31:16];
         end
      end
   end

   // servo flag updates only when a program is invoked and checked
   always_ff @(posedge clk) begin
      if (rst) begin
         srv_flag_reg <= 1'b0;
         srv_det_reg[0] <= 16'h0000;
         srv_det_reg[1] <= 16'h0000;
      end else if (servo_prog_check) begin
         srv_flag_reg <= servo_prog_bad;
         if (servo_prog_bad) begin
            srv_det_reg[0] <= servo_prog_error_info[15:0];
            srv_det_reg[1] <= servo_prog_error_info[31:16];
         end
      end
   end

   // ***********************************
   // peer cpu flags
   // ***********************************
   // read done flags are sticky; software clears them by writing one
   always_ff @(posedge clk) begin
      if (rst) begin
         done_reg <= '0;
      end else begin
         for (int c = 0; c < NCPU; c++) begin
            if (peer_read_ok[c]) begin
               done_reg[c] <= 1'b1;
            end else if (wr_en && hit(paddr, `MCSF_OFF_PEER)
                         && pwdata[`MCSF_PEER_DONE_LSB + c]) begin
               done_reg[c] <= 1'b0;
            end
         end
      end
   end

   // reset view: own reset, removal, or cpu one dragging the others down
   always_comb begin
      in_reset_next = cpu_in_reset | cpu_removed;
      if (in_reset_next[0]) begin
         in_reset_next = '1;
      end
      down_next = |in_reset_next[NCPU-1:1] && !in_reset_next[0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_reset_reg <= '0;
         multi_cpu_down <= 1'b0;
      end else begin
         in_reset_reg <= in_reset_next;
         multi_cpu_down <= down_next;
      end
   end

   // stop error masked by the reset view, so it clears while cpu one is in reset; continuation errors ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         stop_reg <= '0;
      end else begin
         stop_reg <= cpu_stop_error & ~in_reset_next;
      end
   end

   // ***********************************
   // interrupts
   // ***********************************
   assign irq_event = {peer_read_ok,
                       down_next && !multi_cpu_down,
                       servo_prog_check && servo_prog_bad,
                       test_req_fail && !trq_flag_reg,
                       |pulse_gen_axis_setting_bad && !pga_flag_reg};

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_reg <= `MCSF_IRQ_RESET;
         irq_mask_reg <= `MCSF_IRQ_RESET;
      end else begin
         if (wr_en && hit(paddr, `MCSF_OFF_IRQ_STAT)) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`MCSF_IRQ_W-1:0]) | irq_event;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
         end
         if (wr_en && hit(paddr, `MCSF_OFF_IRQ_MASK)) begin
            irq_mask_reg <= pwdata[`MCSF_IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_reg | irq_event) & irq_mask_reg);
      end
   end

   // ***********************************
   // apb slave
   // ***********************************
   // pready rises one cycle into the access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_reg <= mcsf_pkg::MCSF_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `MCSF_RESET_WORD;
      end else begin
         case (phase_reg)
            mcsf_pkg::MCSF_IDLE: begin
               pready <= 1'b0;
               if (psel && !penable) begin
                  phase_reg <= mcsf_pkg::MCSF_SETUP;
               end
            end
            mcsf_pkg::MCSF_SETUP: begin
               if (psel && penable) begin
                  phase_reg <= mcsf_pkg::MCSF_ACCESS;
                  pready <= 1'b1;
                  pslverr <= (paddr > `MCSF_OFF_DOWN_CODE) || (paddr[1:0] != 2'b00);
                  prdata <= `MCSF_RESET_WORD;
                  if (!pwrite) begin
                     case (paddr)
                        `MCSF_OFF_FLAGS: prdata <= {28'h0000000, multi_cpu_down,
                           srv_flag_reg, trq_flag_reg, pga_flag_reg};
                        `MCSF_OFF_PEER: prdata <= {20'h00000, stop_reg,
                           in_reset_reg, done_reg};
                        `MCSF_OFF_PGA_DET0: prdata <= {16'h0000, pga_det_reg[0]};
                        `MCSF_OFF_PGA_DET1: prdata <= {16'h0000, pga_det_reg[1]};
                        `MCSF_OFF_PGA_DET2: prdata <= {16'h0000, pga_det_reg[2]};
                        `MCSF_OFF_TRQ_DET0: prdata <= {16'h0000, trq_det_reg[0]};
                        `MCSF_OFF_TRQ_DET1: prdata <= {16'h0000, trq_det_reg[1]};
                        `MCSF_OFF_SRV_DET0: prdata <= {16'h0000, srv_det_reg[0]};
                        `MCSF_OFF_SRV_DET1: prdata <= {16'h0000, srv_det_reg[1]};
                        `MCSF_OFF_IRQ_STAT: prdata <= {24'h000000, irq_stat_reg};
                        `MCSF_OFF_IRQ_MASK: prdata <= {24'h000000, irq_mask_reg};
                        `MCSF_OFF_DOWN_CODE: prdata <= multi_cpu_down ?
                           {16'h0000, `MCSF_DOWN_ERR_CODE} : `MCSF_RESET_WORD;
                        default: prdata <= `MCSF_RESET_WORD;
                     endcase
                  end
               end else if (!psel) begin
                  phase_reg <= mcsf_pkg::MCSF_IDLE;
               end
            end
            mcsf_pkg::MCSF_ACCESS: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               phase_reg <= (psel && !penable) ? mcsf_pkg::MCSF_SETUP : mcsf_pkg::MCSF_IDLE;
            end
            default: begin
               phase_reg <= mcsf_pkg::MCSF_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   pga_flag_level_a: assert property (@(posedge clk) disable iff (rst)
      $past(!rst) |-> pga_flag_reg == |$past(pulse_gen_axis_setting_bad))
      else $error("pulse axis flag does not follow setting checks");
   pga_detail_cap_a: assert property (@(posedge clk) disable iff (rst)
      (|pulse_gen_axis_setting_bad && !pga_flag_reg) |=>
      pga_det_reg[0] == $past(pulse_gen_axis_error_info[15:0]))
      else $error("pulse axis detail not captured");
   trq_flag_follow_a: assert property (@(posedge clk) disable iff (rst)
      test_req_fail |=> trq_flag_reg)
      else $error("test request flag not set");
   trq_detail_cap_a: assert property (@(posedge clk) disable iff (rst)
      (test_req_fail && !trq_flag_reg) |=>
      trq_det_reg[1] == $past(test_req_error_info[31:16]))
      else $error("test request detail not captured");
   srv_flag_check_a: assert property (@(posedge clk) disable iff (rst)
      servo_prog_check |=> srv_flag_reg == $past(servo_prog_bad))
      else $error("servo flag wrong after check");
   srv_detail_cap_a: assert property (@(posedge clk) disable iff (rst)
      (servo_prog_check && servo_prog_bad) |=>
      srv_det_reg[0] == $past(servo_prog_error_info[15:0]))
      else $error("servo detail not captured");
   read_done_set_a: assert property (@(posedge clk) disable iff (rst)
      peer_read_ok[NCPU-1] |=> done_reg[NCPU-1])
      else $error("read done flag not set");
   cpu1_reset_all_a: assert property (@(posedge clk) disable iff (rst)
      (cpu_in_reset[0] || cpu_removed[0]) |=> &in_reset_reg && !multi_cpu_down)
      else $error("cpu one reset not propagated");
   down_error_a: assert property (@(posedge clk) disable iff (rst)
      (cpu_in_reset[1] && !cpu_in_reset[0] && !cpu_removed[0]) |=> multi_cpu_down)
      else $error("multi cpu down not raised");
   stop_cont_a: assert property (@(posedge clk) disable iff (rst)
      (!cpu_stop_error[1] && cpu_cont_error[1]) |=> !stop_reg[1])
      else $error("continuation error set stop flag");

   // peer reset view: own reset, removal, release and the down flag clear
   in_reset_view_a: assert property (@(posedge clk) disable iff (rst)
      (cpu_in_reset[3] || cpu_removed[3]) |=> in_reset_reg[3])
      else $error("cpu reset flag not raised");
   removed_reset_a: assert property (@(posedge clk) disable iff (rst)
      cpu_removed[2] |=> in_reset_reg[2])
      else $error("removed cpu not counted as resetting");
   reset_release_a: assert property (@(posedge clk) disable iff (rst)
      (!cpu_in_reset[2] && !cpu_removed[2] && !cpu_in_reset[0] && !cpu_removed[0])
      |=> !in_reset_reg[2])
      else $error("cpu reset flag not released");
   down_clear_a: assert property (@(posedge clk) disable iff (rst)
      (in_reset_next[NCPU-1:1] == '0) |=> !multi_cpu_down)
      else $error("multi cpu down raised with peers running");

   // stop flags and read done flags
   stop_flag_set_a: assert property (@(posedge clk) disable iff (rst)
      (cpu_stop_error[0] && !cpu_in_reset[0] && !cpu_removed[0]) |=> stop_reg[0])
      else $error("stop error flag not raised");
   read_done_cpu1_a: assert property (@(posedge clk) disable iff (rst)
      peer_read_ok[0] |=> done_reg[0])
      else $error("cpu one read done flag not set");
   done_clear_a: assert property (@(posedge clk) disable iff (rst)
      (wr_en && hit(paddr, `MCSF_OFF_PEER) && pwdata[0] && !peer_read_ok[0]) |=> !done_reg[0])
      else $error("read done flag not cleared by write one");

   // servo flag, pulse axis and test request details hold between events; the test request flag clears
   trq_flag_clear_a: assert property (@(posedge clk) disable iff (rst)
      !test_req_fail |=> !trq_flag_reg)
      else $error("test request flag stuck");
   srv_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      !servo_prog_check |=> $stable(srv_flag_reg))
      else $error("servo flag changed without a check");
   pga_detail_hold_a: assert property (@(posedge clk) disable iff (rst)
      (pga_flag_reg && |pulse_gen_axis_setting_bad) |=> $stable(pga_det_reg[0]))
      else $error("pulse axis detail overwritten");
   trq_detail_hold_a: assert property (@(posedge clk) disable iff (rst)
      trq_flag_reg |=> $stable(trq_det_reg[1]))
      else $error("test request detail overwritten");

   // bus beat and interrupt level
   pready_pulse_a: assert property (@(posedge clk) disable iff (rst)
      pready |=> !pready)
      else $error("pready held longer than one cycle");
   slverr_beat_a: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready)
      else $error("pslverr without pready");
   irq_level_a: assert property (@(posedge clk) disable iff (rst)
      |(irq_stat_reg & irq_mask_reg) |=> irq)
      else $error("irq low with an unmasked status bit");

   // main scenarios
   cover_pga: cover property (@(posedge clk) disable iff (rst) $rose(pga_flag_reg));
   cover_down: cover property (@(posedge clk) disable iff (rst) $rose(multi_cpu_down));
   cover_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   cover_stop: cover property (@(posedge clk) disable iff (rst) $fell(stop_reg[0]));
   cover_done: cover property (@(posedge clk) disable iff (rst) &done_reg);
endmodule : mcsf_status_flags

// *** tb/mcsf_peer_model.sv ***
// peer cpu side model: read completions, reset, removal and error states
`timescale 1ns/100ps
module mcsf_peer_model (
   // clock
   input wire logic clk,
   // peer status toward the flag bank
   output logic [3:0] peer_read_ok,
   output logic [3:0] cpu_in_reset,
   output logic [3:0] cpu_removed,
   output logic [3:0] cpu_stop_error,
   output logic [3:0] cpu_cont_error
);
   // all peers running and healthy at time zero
   initial begin
      peer_read_ok = 4'h0;
      cpu_in_reset = 4'h0;
      cpu_removed = 4'h0;
      cpu_stop_error = 4'h0;
      cpu_cont_error = 4'h0;
   end
   // one-cycle completion pulse, prompt or late as the caller asks
   task automatic read_done(input int n, input int dly);
      repeat (dly) @(posedge clk);
      peer_read_ok[n] <= 1'b1;
      @(posedge clk);
      peer_read_ok[n] <= 1'b0;
   endtask : read_done
   // cause must go first, or the stop flags return once cpu one leaves reset
   task automatic clear_stop();
      @(posedge clk);
      cpu_stop_error <= 4'h0;
      @(posedge clk);
      cpu_in_reset[0] <= 1'b1;
      repeat (3) @(posedge clk);
      cpu_in_reset[0] <= 1'b0;
   endtask : clear_stop
endmodule : mcsf_peer_model

// *** tb/multi_cpu_status_flags_tb_top.sv ***
// self-checking bench of the status flag bank
`timescale 1ns/100ps
`include "mcsf_defines.svh"
module multi_cpu_status_flags_tb_top;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, tfail, schk, sbad, down, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, tinfo, sinfo, rd;
   logic [5:0] pbad;
   logic [47:0] pinfo;
   logic [63:0] rnd;
   logic [3:0] rok, rin, rrem, rstp, rcon;
   logic err;
   int fail_count, tests_run, i, j, exp_done;
   // ***********************************
   // design and peer model
   // ***********************************
   mcsf_status_flags #(.NCPU(4), .NAXW(6)) i_dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pulse_gen_axis_setting_bad(pbad),
      .pulse_gen_axis_error_info(pinfo), .test_req_fail(tfail), .test_req_error_info(tinfo),
      .servo_prog_check(schk), .servo_prog_bad(sbad), .servo_prog_error_info(sinfo),
      .peer_read_ok(rok), .cpu_in_reset(rin), .cpu_removed(rrem), .cpu_stop_error(rstp),
      .cpu_cont_error(rcon), .multi_cpu_down(down), .irq(irq));
   mcsf_peer_model i_peer (.clk(clk), .peer_read_ok(rok), .cpu_in_reset(rin),
      .cpu_removed(rrem), .cpu_stop_error(rstp), .cpu_cont_error(rcon));
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // reference of the peer word: removal and cpu one reset widen the reset set
   function automatic logic [31:0] peer_exp(input int done);
      logic [3:0] r;
      r = rin | rrem;
      if (r[0]) r = 4'hf;
      return {20'h0, rstp & ~r, r, done[3:0]};
   endfunction : peer_exp
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(what, rd, e);
   endtask : rchk
   // the expectation is taken only after the inputs have landed
   task automatic pchk(input string what);
      apb(1'b0, `MCSF_OFF_PEER, 32'h0);
      check(what, rd, peer_exp(exp_done));
   endtask : pchk
   task automatic servo(input logic b, input logic [31:0] d);
      @(posedge clk);
      schk <= 1'b1;
      sbad <= b;
      sinfo <= d;
      @(posedge clk);
      schk <= 1'b0;
   endtask : servo
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   // watchdog, far beyond the few hundred cycles of the run
   initial begin
      #1000000;
      fail_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, tfail, tinfo, schk, sbad, sinfo} = '0;
      rst = 1'b1;
      pbad = 6'h00;
      pinfo = 48'h0;
      exp_done = 0;
      void'($urandom(32'h9bf6));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i <= 12'h2c; i += 4) rchk("reset value", 12'(i), 32'h0);
      apb(1'b1, `MCSF_OFF_FLAGS, 32'hffff);
      rchk("read only", `MCSF_OFF_FLAGS, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      apb(1'b0, 12'h002, 32'h0);
      check("unaligned err", 32'(err), 32'h1);
      $display("test registers done");
      for (i = 0; i < 6; i++) begin
         rnd = {$urandom(), $urandom()};
         @(posedge clk);
         pbad <= 6'h01 << i;
         pinfo <= rnd[47:0];
         rchk("pga flag", `MCSF_OFF_FLAGS, 32'h1);
         for (j = 0; j < 3; j++) rchk("pga detail", 12'(8 + 4 * j), 32'(rnd[16*j +: 16]));
         @(posedge clk);
         pinfo <= ~rnd[47:0];
         rchk("pga detail held", `MCSF_OFF_PGA_DET0, 32'(rnd[15:0]));
         @(posedge clk);
         pbad <= 6'h00;
         rchk("pga clear", `MCSF_OFF_FLAGS, 32'h0);
      end
      $display("test pulse axis done");
      @(posedge clk);
      tfail <= 1'b1;
      tinfo <= rnd[63:32];
      rchk("trq flag", `MCSF_OFF_FLAGS, 32'h2);
      rchk("trq detail0", `MCSF_OFF_TRQ_DET0, 32'(rnd[47:32]));
      rchk("trq detail1", `MCSF_OFF_TRQ_DET1, 32'(rnd[63:48]));
      @(posedge clk);
      tfail <= 1'b0;
      rchk("trq clear", `MCSF_OFF_FLAGS, 32'h0);
      $display("test request done");
      servo(1'b0, 32'h0);
      rchk("srv good", `MCSF_OFF_FLAGS, 32'h0);
      for (j = 0; j < 2; j++) begin
         rnd = {$urandom(), $urandom()};
         servo(1'b1, rnd[31:0]);
         rchk("srv flag", `MCSF_OFF_FLAGS, 32'h4);
         rchk("srv detail0", `MCSF_OFF_SRV_DET0, 32'(rnd[15:0]));
         rchk("srv detail1", `MCSF_OFF_SRV_DET1, 32'(rnd[31:16]));
      end
      servo(1'b0, 32'h0);
      rchk("srv clear", `MCSF_OFF_FLAGS, 32'h0);
      $display("test servo done");
      apb(1'b1, `MCSF_OFF_IRQ_STAT, 32'hff);
      apb(1'b1, `MCSF_OFF_IRQ_MASK, 32'h0f);
      for (i = 0; i < 4; i++) begin
         i_peer.read_done(i, i);
         exp_done |= 1 << i;
         pchk("read done");
      end
      check("irq masked", 32'(irq), 32'h0);
      rchk("irq status", `MCSF_OFF_IRQ_STAT, 32'hf0);
      apb(1'b1, `MCSF_OFF_IRQ_MASK, 32'hf0);
      repeat (3) @(posedge clk);
      check("irq raised", 32'(irq), 32'h1);
      apb(1'b1, `MCSF_OFF_PEER, 32'h5);
      exp_done = 32'ha;
      pchk("done clear");
      apb(1'b1, `MCSF_OFF_IRQ_STAT, 32'hff);
      repeat (3) @(posedge clk);
      check("irq cleared", 32'(irq), 32'h0);
      $display("test read done done");
      for (i = 1; i < 4; i++) begin
         @(posedge clk);
         i_peer.cpu_in_reset[i] <= 1'b1;
         pchk("peer reset");
         rchk("down flag", `MCSF_OFF_FLAGS, 32'h8);
         rchk("down code", `MCSF_OFF_DOWN_CODE, 32'h1b58);
         check("down pin", 32'(down), 32'h1);
         @(posedge clk);
         i_peer.cpu_in_reset[i] <= 1'b0;
         pchk("peer release");
      end
      @(posedge clk);
      i_peer.cpu_removed[2] <= 1'b1;
      pchk("removed");
      rchk("removed down", `MCSF_OFF_FLAGS, 32'h8);
      @(posedge clk);
      i_peer.cpu_removed[2] <= 1'b0;
      i_peer.cpu_stop_error <= 4'h5;
      i_peer.cpu_cont_error <= 4'ha;
      pchk("stop flags");
      @(posedge clk);
      i_peer.cpu_in_reset[0] <= 1'b1;
      pchk("cpu1 reset");
      rchk("no down", `MCSF_OFF_FLAGS, 32'h0);
      check("no down pin", 32'(down), 32'h0);
      @(posedge clk);
      i_peer.cpu_in_reset[0] <= 1'b0;
      i_peer.clear_stop();
      pchk("stop cleared");
      $display("test peer state done");
      end_of_test();
   end
endmodule : multi_cpu_status_flags_tb_top
